//--- core/irq_line_map.sv
// peripheral flag/enable gathering, line mapping and prioritising interrupt controller
//
// What this block does
// - peripheral flag sets when its condition occurs
// - enable-set write of one enables source
// - enable-clear write of one disables source
// - source request equals flag and enable
// - one peripheral's requests ORed into one
// - request sets line pending; software sets/clears
// - pending line activates only when enabled
// - 32 lines, four priority levels each
// - priority registers hold field per line
// - 23 lines each wired to one peripheral
// - external unit NMI drives core NMI
// - system peripherals on lines 0 to 6
// - serial units 0..5 on lines 7..12
// - timers 0..7 on lines 13..20
// - converter line 21, comparator line 22
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "irq_map_cfg.svh"
module irq_line_map
	import irq_map_pkg::*;
#(
	parameter int N_PERIPH = PERIPH_COUNT,
	parameter int N_SRC = SRC_PER_PERIPH,
	parameter int N_LINE = LINE_COUNT
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// per-peripheral interrupt conditions, one-cycle pulses, peripheral index order
	input wire logic [N_PERIPH*N_SRC-1:0] periph_cond_i,
	// nmi condition pulse of the external interrupt unit
	input wire logic ext_nmi_cond_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	output logic core_irq_valid_o,
	output logic [4:0] core_irq_line_o,
	output logic [1:0] core_irq_prio_o,
	output logic core_nmi_o,
	output logic irq_o
);
	// peripheral index order: pm, system_control_unit, wdt, rtc, eic, nvm, event_system, ser0..5, tc0..7, adc, ac
	reg_req_s req;
	src_vec_t flag_r [N_PERIPH];
	src_vec_t en_r [N_PERIPH];
	logic [N_PERIPH-1:0] periph_req;
	logic [N_LINE-1:0] line_req;
	logic [N_LINE-1:0] line_en_r;
	logic [N_LINE-1:0] line_pend_r;
	prio_t prio_r [N_LINE];
	logic [4:0] periph_sel_r;
	logic nmi_flag_r;
	logic nmi_en_r;
	active_line_s act_nxt;
	active_line_s act_r;
	logic [1:0] status_r;
	logic [1:0] mask_r;
	logic [1:0] status_set;
	logic rd_status;
	logic [31:0] rdata_nxt;
	logic [N_LINE-1:0] line_pend_nxt;

	assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	function automatic logic sel_ok(input logic [4:0] s);
		sel_ok = (32'(s) < N_PERIPH);
	endfunction : sel_ok

	// per-peripheral flags and enables
	for (genvar p = 0; p < N_PERIPH; p++) begin : g_periph
		logic sel;
		assign sel = (periph_sel_r == 5'(p));
		always_ff @(posedge mclk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				flag_r[p] <= `PERIPH_EN_RST;
			end else begin
				// set wins over a simultaneous write-one-to-clear
				flag_r[p] <= (flag_r[p] & ~((req.wr && sel && hit(req.addr, `PERIPH_FLAG_OFS))
					? req.wdata[N_SRC-1:0] : '0)) | periph_cond_i[p*N_SRC +: N_SRC];
			end
		end
		always_ff @(posedge mclk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				en_r[p] <= `PERIPH_EN_RST;
			end else if (req.wr && sel && hit(req.addr, `PERIPH_ENSET_OFS)) begin
				en_r[p] <= en_r[p] | req.wdata[N_SRC-1:0];
			end else if (req.wr && sel && hit(req.addr, `PERIPH_ENCLR_OFS)) begin
				en_r[p] <= en_r[p] & ~req.wdata[N_SRC-1:0];
			end
		end
		assign periph_req[p] = |(flag_r[p] & en_r[p]);
	end

	always_comb begin
		line_req = '0;
		line_req[`LINE_POWER_MANAGER] = periph_req[0];
		line_req[`LINE_SYSTEM_CONTROL] = periph_req[1];
		line_req[`LINE_WATCHDOG] = periph_req[2];
		line_req[`LINE_RTC] = periph_req[3];
		line_req[`LINE_EXT_INT] = periph_req[4];
		line_req[`LINE_NVM_CTRL] = periph_req[5];
		line_req[`LINE_EVENT_SYSTEM] = periph_req[6];
		for (int s = 0; s < 6; s++) begin
			line_req[`LINE_SERIAL_FIRST + s] = periph_req[7 + s];
		end
		for (int t = 0; t < 8; t++) begin
			line_req[`LINE_TIMER_FIRST + t] = periph_req[13 + t];
		end
		line_req[`LINE_ADC] = periph_req[21];
		line_req[`LINE_ANALOG_COMP] = periph_req[22];
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			nmi_flag_r <= 1'b0;
			nmi_en_r <= 1'b0;
		end else begin
			nmi_flag_r <= (nmi_flag_r & ~(req.wr && hit(req.addr, `NMI_STATE_OFS)
				&& req.wdata[0])) | ext_nmi_cond_i;
			if (req.wr && hit(req.addr, `NMI_STATE_OFS)) begin
				nmi_en_r <= req.wdata[1];
			end
		end
	end
	assign core_nmi_o = nmi_flag_r & nmi_en_r;

	// peripheral selector for the window registers
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			periph_sel_r <= 5'h00;
		end else if (req.wr && hit(req.addr, `PERIPH_SEL_OFS) && sel_ok(req.wdata[4:0])) begin
			periph_sel_r <= req.wdata[4:0];
		end
	end

	// line enables by set/clear
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			line_en_r <= `LINE_ENABLE_RST;
		end else if (req.wr && hit(req.addr, `LINE_ENABLE_SET_OFS)) begin
			line_en_r <= line_en_r | req.wdata[N_LINE-1:0];
		end else if (req.wr && hit(req.addr, `LINE_ENABLE_CLEAR_OFS)) begin
			line_en_r <= line_en_r & ~req.wdata[N_LINE-1:0];
		end
	end

	// pending set by request or software
	always_comb begin
		line_pend_nxt = line_pend_r;
		if (req.wr && hit(req.addr, `LINE_PENDING_CLEAR_OFS)) begin
			line_pend_nxt = line_pend_nxt & ~req.wdata[N_LINE-1:0];
		end
		if (req.wr && hit(req.addr, `LINE_PENDING_SET_OFS)) begin
			line_pend_nxt = line_pend_nxt | req.wdata[N_LINE-1:0];
		end
		// a level request re-pends after a clear while still asserted
		line_pend_nxt = line_pend_nxt | line_req;
	end
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			line_pend_r <= `LINE_PENDING_RST;
		end else begin
			line_pend_r <= line_pend_nxt;
		end
	end

	// priority fields, four lines per word
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int l = 0; l < N_LINE; l++) begin
				prio_r[l] <= `LINE_PRIO_RST;
			end
		end else if (req.wr && req.addr >= `LINE_PRIO_BASE_OFS
			&& req.addr <= `LINE_PRIO_LAST_OFS) begin
			for (int b = 0; b < `PRIO_LINES_PER_REG; b++) begin
				prio_r[32'(req.addr[5:2] - 4'h4) * `PRIO_LINES_PER_REG + b] <=
					req.wdata[b*8 + `PRIO_FIELD_POS +: 2];
			end
		end
	end

	// pick enabled pending, lowest level value first, then lowest line
	always_comb begin
		act_nxt = '{valid: 1'b0, line: 5'h00, prio: 2'h3};
		for (int l = N_LINE - 1; l >= 0; l--) begin
			if (line_pend_r[l] && line_en_r[l]
				&& (!act_nxt.valid || prio_r[l] <= act_nxt.prio)) begin
				act_nxt = '{valid: 1'b1, line: 5'(l), prio: prio_r[l]};
			end
		end
	end
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			act_r <= '0;
		end else begin
			act_r <= act_nxt;
		end
	end
	assign core_irq_valid_o = act_r.valid;
	assign core_irq_line_o = act_r.line;
	assign core_irq_prio_o = act_r.prio;

	// block status: bit0 line became active, bit1 nmi raised
	assign rd_status = req.rd && hit(req.addr, `IRQ_STATUS_OFS);
	assign status_set = {ext_nmi_cond_i, act_nxt.valid & ~act_r.valid};
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			status_r <= 2'h0;
		end else begin
			// set beats the clear-on-read
			status_r <= (rd_status ? 2'h0 : status_r) | status_set;
		end
	end
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mask_r <= `IRQ_MASK_RST;
		end else if (req.wr && hit(req.addr, `IRQ_MASK_OFS)) begin
			mask_r <= req.wdata[1:0];
		end
	end
	assign irq_o = |(status_r & mask_r);

	// read mux; unmapped reads return zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		unique case (1'b1)
			hit(req.addr, `LINE_ENABLE_SET_OFS), hit(req.addr, `LINE_ENABLE_CLEAR_OFS): begin
				rdata_nxt = line_en_r;
			end
			hit(req.addr, `LINE_PENDING_SET_OFS), hit(req.addr, `LINE_PENDING_CLEAR_OFS): begin
				rdata_nxt = line_pend_r;
			end
			(req.addr >= `LINE_PRIO_BASE_OFS && req.addr <= `LINE_PRIO_LAST_OFS): begin
				for (int b = 0; b < `PRIO_LINES_PER_REG; b++) begin
					rdata_nxt[b*8 + `PRIO_FIELD_POS +: 2] =
						prio_r[32'(req.addr[5:2] - 4'h4) * `PRIO_LINES_PER_REG + b];
				end
			end
			hit(req.addr, `LINE_ACTIVE_OFS): rdata_nxt = {24'h0, act_r.valid, act_r.line, act_r.prio};
			hit(req.addr, `LINE_RAW_REQ_OFS): rdata_nxt = line_req;
			hit(req.addr, `IRQ_STATUS_OFS): rdata_nxt = {30'h0, status_r};
			hit(req.addr, `IRQ_MASK_OFS): rdata_nxt = {30'h0, mask_r};
			hit(req.addr, `NMI_STATE_OFS): rdata_nxt = {29'h0, core_nmi_o, nmi_en_r, nmi_flag_r};
			hit(req.addr, `PERIPH_SEL_OFS): rdata_nxt = {27'h0, periph_sel_r};
			hit(req.addr, `PERIPH_FLAG_OFS): rdata_nxt = 32'(flag_r[periph_sel_r]);
			hit(req.addr, `PERIPH_ENSET_OFS), hit(req.addr, `PERIPH_ENCLR_OFS): begin
				rdata_nxt = 32'(en_r[periph_sel_r]);
			end
			hit(req.addr, `PERIPH_REQ_OFS): rdata_nxt = 32'(periph_req);
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (req.rd) begin
			reg_rdata_o <= rdata_nxt;
		end else begin
			reg_rdata_o <= 32'h0000_0000;
		end
	end
endmodule : irq_line_map

//--- core/irq_map_cfg.svh
// offsets, field positions, reset values and line numbers of the interrupt line mapping block
`ifndef IRQ_MAP_CFG_SVH
`define IRQ_MAP_CFG_SVH
// register bus word addresses
`define LINE_ENABLE_SET_OFS 8'h00
`define LINE_ENABLE_CLEAR_OFS 8'h04
`define LINE_PENDING_SET_OFS 8'h08
`define LINE_PENDING_CLEAR_OFS 8'h0c
`define LINE_PRIO_BASE_OFS 8'h10
`define LINE_PRIO_LAST_OFS 8'h2c
`define LINE_ACTIVE_OFS 8'h30
`define LINE_RAW_REQ_OFS 8'h34
`define IRQ_STATUS_OFS 8'h38
`define IRQ_MASK_OFS 8'h3c
`define NMI_STATE_OFS 8'h40
`define ACTIVE_SEL_OFS 8'h44
`define PERIPH_SEL_OFS 8'h48
`define PERIPH_FLAG_OFS 8'h4c
`define PERIPH_ENSET_OFS 8'h50
`define PERIPH_ENCLR_OFS 8'h54
`define PERIPH_REQ_OFS 8'h58
// field layout of one priority register: four lines, two bits each at bytes' top
`define PRIO_FIELD_POS 6
`define PRIO_LINES_PER_REG 4
// reset values
`define LINE_ENABLE_RST 32'h0000_0000
`define LINE_PENDING_RST 32'h0000_0000
`define LINE_PRIO_RST 2'h0
`define IRQ_MASK_RST 2'h0
`define PERIPH_EN_RST 8'h00
// line assignment
`define LINE_POWER_MANAGER 0
`define LINE_SYSTEM_CONTROL 1
`define LINE_WATCHDOG 2
`define LINE_RTC 3
`define LINE_EXT_INT 4
`define LINE_NVM_CTRL 5
`define LINE_EVENT_SYSTEM 6
`define LINE_SERIAL_FIRST 7
`define LINE_TIMER_FIRST 13
`define LINE_ADC 21
`define LINE_ANALOG_COMP 22
`endif

//--- core/irq_map_pkg.sv
// types shared by the interrupt line mapping block
package irq_map_pkg;
	localparam int PERIPH_COUNT = 23;
	localparam int SRC_PER_PERIPH = 8;
	localparam int LINE_COUNT = 32;
	typedef logic [1:0] prio_t;
	typedef logic [SRC_PER_PERIPH-1:0] src_vec_t;
	// register bus request travelling as one bundle
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} reg_req_s;
	// currently selected line for the core
	typedef struct packed {
		logic valid;
		logic [4:0] line;
		prio_t prio;
	} active_line_s;
endpackage : irq_map_pkg

//--- tb/irq_line_map_monitor.sv
// concurrent checks on the interrupt line mapping block ports
`timescale 1ns/10ps
`include "irq_map_cfg.svh"
module irq_line_map_monitor
	import irq_map_pkg::*;
#(
	parameter int N_PERIPH = PERIPH_COUNT,
	parameter int N_SRC = SRC_PER_PERIPH
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic [N_PERIPH*N_SRC-1:0] periph_cond_i,
	input wire logic ext_nmi_cond_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic core_irq_valid_o,
	input wire logic [4:0] core_irq_line_o,
	input wire logic [1:0] core_irq_prio_o,
	input wire logic core_nmi_o,
	input wire logic irq_o
);
	// recent causes; outputs may only rise a few cycles after one
	logic [7:0] cause_r;
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cause_r <= 8'h00;
		end else begin
			cause_r <= {cause_r[6:0], reg_wr_i | ext_nmi_cond_i | (|periph_cond_i)};
		end
	end
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);
	chk_rdata_slot: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
		else $error("read data outside reply cycle");
	chk_valid_cause: assert property ($rose(core_irq_valid_o) |-> |cause_r)
		else $error("line active without cause");
	chk_valid_hold: assert property (core_irq_valid_o && !$past(reg_wr_i) |=> core_irq_valid_o)
		else $error("active line dropped without write");
	chk_irq_cause: assert property ($rose(irq_o) |-> |cause_r)
		else $error("interrupt raised without cause");
	chk_nmi_cause: assert property ($rose(core_nmi_o) |-> |cause_r[1:0])
		else $error("nmi raised without cause");
	chk_nmi_hold: assert property (core_nmi_o && !reg_wr_i |=> core_nmi_o)
		else $error("nmi dropped without write");
	chk_active_read: assert property (reg_rd_i && reg_addr_i == `LINE_ACTIVE_OFS |=>
		reg_rdata_o[7:0] == {$past(core_irq_valid_o), $past(core_irq_line_o), $past(core_irq_prio_o)})
		else $error("active register differs from core outputs");
	chk_nmi_read: assert property (reg_rd_i && reg_addr_i == `NMI_STATE_OFS |=>
		reg_rdata_o[2] == $past(core_nmi_o))
		else $error("nmi state differs from nmi output");
endmodule : irq_line_map_monitor
bind irq_line_map irq_line_map_monitor #(.N_PERIPH(N_PERIPH), .N_SRC(N_SRC)) i_irq_line_map_monitor (
	.mclk_i(mclk_i), .rst_b_i(rst_b_i), .periph_cond_i(periph_cond_i),
	.ext_nmi_cond_i(ext_nmi_cond_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .core_irq_valid_o(core_irq_valid_o),
	.core_irq_line_o(core_irq_line_o), .core_irq_prio_o(core_irq_prio_o),
	.core_nmi_o(core_nmi_o), .irq_o(irq_o));

//--- tb/irq_line_map_test.sv
// self-checking testbench of the interrupt line mapping block
`timescale 1ns/10ps
`include "irq_map_cfg.svh"
module irq_line_map_test
	import irq_map_pkg::*;
;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, fire = 1'b0, nmi_fire = 1'b0;
	logic [7:0] reg_addr_i = 8'h00, idx = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
	logic [PERIPH_COUNT*SRC_PER_PERIPH-1:0] periph_cond_i;
	logic ext_nmi_cond_i, core_irq_valid_o, core_nmi_o, irq_o;
	logic [4:0] core_irq_line_o;
	logic [1:0] core_irq_prio_o;
	int error_cnt = 0, checked = 0;
	always #5 mclk_i = ~mclk_i;
	irq_line_map i_irq_line_map (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .periph_cond_i(periph_cond_i),
		.ext_nmi_cond_i(ext_nmi_cond_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.core_irq_valid_o(core_irq_valid_o), .core_irq_line_o(core_irq_line_o),
		.core_irq_prio_o(core_irq_prio_o), .core_nmi_o(core_nmi_o), .irq_o(irq_o));
	periph_model i_periph_model (.mclk_i(mclk_i), .fire_i(fire), .nmi_i(nmi_fire), .idx_i(idx),
		.cond_o(periph_cond_i), .nmi_o(ext_nmi_cond_i));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	// data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge mclk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1;
		check(what, reg_rdata_o, exp);
	endtask : rd
	task automatic idle(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : idle
	task automatic pulse(input logic [7:0] i, input logic n);
		@(posedge mclk_i);
		fire <= ~n;
		nmi_fire <= n;
		idx <= i;
		@(posedge mclk_i);
		fire <= 1'b0;
		nmi_fire <= 1'b0;
	endtask : pulse
	task automatic reset_test();
		rd(`LINE_ENABLE_SET_OFS, `LINE_ENABLE_RST, "enable");
		rd(`LINE_PENDING_SET_OFS, `LINE_PENDING_RST, "pending");
		rd(`LINE_PRIO_LAST_OFS, 32'h0, "prio");
		wr(8'h44, 32'hffff_ffff);
		rd(8'h44, 32'h0, "unused");
	endtask : reset_test
	task automatic map_test();
		logic [31:0] s;
		for (int p = 0; p < PERIPH_COUNT; p++) begin
			s = 32'h1 << (p % SRC_PER_PERIPH);
			wr(`PERIPH_SEL_OFS, 32'(p));
			wr(`PERIPH_ENSET_OFS, s);
			pulse(8'(p * SRC_PER_PERIPH + p % SRC_PER_PERIPH), 1'b0);
			idle(4);
			rd(`PERIPH_FLAG_OFS, s, "flag");
			rd(`LINE_RAW_REQ_OFS, 32'h1 << p, "line");
			rd(`LINE_PENDING_SET_OFS, 32'h1 << p, "pending");
			check("masked", core_irq_valid_o, 1'b0);
			wr(`LINE_ENABLE_SET_OFS, 32'h1 << p);
			idle(3);
			check("active", {core_irq_valid_o, core_irq_line_o}, {1'b1, p[4:0]});
			wr(`LINE_ENABLE_CLEAR_OFS, 32'h1 << p);
			wr(`PERIPH_ENCLR_OFS, s);
			rd(`LINE_RAW_REQ_OFS, 32'h0, "off");
			rd(`PERIPH_FLAG_OFS, s, "held");
			wr(`PERIPH_FLAG_OFS, s);
			wr(`LINE_PENDING_CLEAR_OFS, 32'h1 << p);
			rd(`LINE_PENDING_SET_OFS, 32'h0, "cleared");
		end
	endtask : map_test
	task automatic prio_test();
		logic [31:0] w[4] = '{32'h4000_80c0, 32'h40c0_80c0, 32'hc0c0_80c0, 32'hc0c0_c0c0};
		logic [7:0] e[4] = '{8'h88, 8'h8d, 8'h86, 8'h83};
		wr(`LINE_PRIO_LAST_OFS, 32'hc080_4000);
		rd(`LINE_PRIO_LAST_OFS, 32'hc080_4000, "prio");
		wr(`LINE_PENDING_SET_OFS, 32'hf);
		wr(`LINE_ENABLE_SET_OFS, 32'hf);
		for (int k = 0; k < 4; k++) begin
			wr(`LINE_PRIO_BASE_OFS, w[k]);
			idle(3);
			rd(`LINE_ACTIVE_OFS, {24'h0, e[k]}, "winner");
			check("winner out", {core_irq_valid_o, core_irq_line_o, core_irq_prio_o}, e[k]);
		end
		wr(`LINE_ENABLE_CLEAR_OFS, 32'hf);
		wr(`LINE_PENDING_CLEAR_OFS, 32'hf);
	endtask : prio_test
	task automatic irq_test();
		check("masked", irq_o, 1'b0);
		rd(`IRQ_STATUS_OFS, 32'h1, "status");
		wr(`IRQ_MASK_OFS, 32'h1);
		wr(`LINE_ENABLE_SET_OFS, 32'h8000_0000);
		wr(`LINE_PENDING_SET_OFS, 32'h8000_0000);
		idle(4);
		check("irq", {irq_o, core_irq_line_o}, 32'h3f);
		rd(`IRQ_STATUS_OFS, 32'h1, "status");
		check("irq off", irq_o, 1'b0);
		wr(`LINE_ENABLE_CLEAR_OFS, 32'h8000_0000);
		wr(`LINE_PENDING_CLEAR_OFS, 32'h8000_0000);
		wr(`IRQ_MASK_OFS, 32'h0);
	endtask : irq_test
	task automatic nmi_test();
		wr(`NMI_STATE_OFS, 32'h2);
		pulse(8'h00, 1'b1);
		idle(3);
		rd(`NMI_STATE_OFS, 32'h7, "nmi");
		rd(`LINE_RAW_REQ_OFS, 32'h0, "no line");
		rd(`IRQ_STATUS_OFS, 32'h2, "event");
		wr(`NMI_STATE_OFS, 32'h3);
		#1;
		check("nmi off", core_nmi_o, 1'b0);
	endtask : nmi_test
	task automatic stop_test();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	initial begin
		repeat (4) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		reset_test();
		map_test();
		prio_test();
		irq_test();
		nmi_test();
		stop_test();
	end
	// whole run needs about nine hundred cycles
	initial begin
		repeat (8000) @(posedge mclk_i);
		error_cnt++;
		stop_test();
	end
endmodule : irq_line_map_test

//--- tb/periph_model.sv
// peripheral side model: interrupt condition pulses on command
`timescale 1ns/10ps
module periph_model
	import irq_map_pkg::*;
(
	input wire logic mclk_i,
	input wire logic fire_i,
	input wire logic nmi_i,
	input wire logic [7:0] idx_i,
	output logic [PERIPH_COUNT*SRC_PER_PERIPH-1:0] cond_o,
	output logic nmi_o
);
	logic [PERIPH_COUNT*SRC_PER_PERIPH-1:0] cond_r = '0;
	logic nmi_r = 1'b0;
	always @(posedge mclk_i) begin
		cond_r <= '0;
		if (fire_i) begin
			cond_r[idx_i] <= 1'b1;
		end
		nmi_r <= nmi_i;
	end
	assign cond_o = cond_r;
	assign nmi_o = nmi_r;
endmodule : periph_model
